// >>> codec_regs_cfg.svh
`ifndef CODEC_REGS_CFG_SVH
`define CODEC_REGS_CFG_SVH

// ------------------------------------------------------------------
// register addresses (bits 6:3 of the address byte)
// ------------------------------------------------------------------
`define ADDR_RX_PATH_DATA_BYTE 4'h2
`define ADDR_TX_FORCED_DATA_BYTE 4'h3
`define ADDR_AUDIO_PATH_CONTROL 4'h4
`define ADDR_TX_AND_SIDETONE_GAIN 4'h5
`define ADDR_OUTPUT_ATTENUATION 4'h6
`define ADDR_TONE_CONTROL 4'h7
`define ADDR_TONE_FREQ_ONE 4'h8
`define ADDR_TONE_FREQ_TWO 4'h9

// ------------------------------------------------------------------
// address byte layout
// ------------------------------------------------------------------
`define CMD_ADDR_MSB 6
`define CMD_ADDR_LSB 3
`define CMD_READ_BIT 2
`define CMD_SECOND_BYTE_BIT 1

// ------------------------------------------------------------------
// audio path control fields
// ------------------------------------------------------------------
`define PATH_INPUT_MSB 7
`define PATH_INPUT_LSB 6
`define PATH_SIDETONE_BIT 5
`define PATH_OUTPUT_MSB 4
`define PATH_OUTPUT_LSB 3
`define PATH_RING_TONE_BIT 2
`define PATH_HIGHPASS_BYPASS_BIT 1
`define PATH_RX_SIGNAL_BIT 0

// ------------------------------------------------------------------
// tone control fields; bit 1 waveform select, all eight bits used
// ------------------------------------------------------------------
`define TONE_ATTEN_MSB 7
`define TONE_ATTEN_LSB 4
`define TONE_SRC_MSB 3
`define TONE_SRC_LSB 2
`define TONE_WAVE_BIT 1
`define TONE_TO_TX_BIT 0
`define TONE_ATTEN_MAX 4'h9

// ------------------------------------------------------------------
// reset value and forbidden output code
// ------------------------------------------------------------------
`define RST_BYTE 8'h00
`define OUTPUT_SEL_FORBIDDEN 2'h3

`endif

// >>> codec_regs_pkg.sv
package codec_regs_pkg;

	// transmit input choice
	typedef enum logic [1:0] {
		TX_IN_MUTE,
		TX_IN_MIC_ONE,
		TX_IN_MIC_TWO,
		TX_IN_MIC_THREE
	} tx_input_type;

	// receive output choice
	typedef enum logic [1:0] {
		RX_OUT_MUTE,
		RX_OUT_EARPIECE,
		RX_OUT_EXTERNAL,
		RX_OUT_FORBIDDEN
	} rx_output_type;

	// serial port sequencer
	typedef enum logic [1:0] {
		PORT_ADDR,
		PORT_DATA,
		PORT_DONE
	} port_state_type;

endpackage

// >>> serial_byte_shifter.sv
`timescale 1ns/100ps
`default_nettype none

// ------------------------------------------------------------------
// byte shifter: msb first in and out, bit moves on a strobe
// ------------------------------------------------------------------
module serial_byte_shifter (
	input wire logic i_clock,
	input wire logic i_rst_n,
	input wire logic i_load,
	input wire logic [7:0] i_load_byte,
	input wire logic i_shift,
	input wire logic i_bit,
	output logic o_bit,
	output logic [7:0] o_byte,
	output logic o_full
);

	logic [7:0] shift_ff;
	logic [2:0] count_ff;
	logic full_ff;

	// load wins over shift so a read byte is never half stale
	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			shift_ff <= 8'h00;
		end else if (i_load) begin
			shift_ff <= i_load_byte;
		end else if (i_shift) begin
			shift_ff <= {shift_ff[6:0], i_bit};
		end
	end

	// bit counter; full pulses after the eighth bit
	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			count_ff <= 3'h0;
			full_ff <= 1'b0;
		end else begin
			full_ff <= i_shift && (count_ff == 3'h7) && !i_load;
			if (i_load) begin
				count_ff <= 3'h0;
			end else if (i_shift) begin
				count_ff <= count_ff + 3'h1;
			end
		end
	end

	assign o_bit = shift_ff[7];
	assign o_byte = shift_ff;
	assign o_full = full_ff;

endmodule // serial_byte_shifter

`default_nettype wire

// >>> edge_sync.sv
`timescale 1ns/100ps
`default_nettype none

// ------------------------------------------------------------------
// two-flop synchroniser with rise and fall pulses on the clean copy
// ------------------------------------------------------------------
module edge_sync (
	input wire logic i_clock,
	input wire logic i_rst_n,
	input wire logic i_pin,
	output logic o_level,
	output logic o_rise,
	output logic o_fall
);

	logic meta_ff;
	logic sync_ff;
	logic prev_ff;

	// only sync_ff reads meta_ff
	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			meta_ff <= 1'b0;
			sync_ff <= 1'b0;
			prev_ff <= 1'b0;
		end else begin
			meta_ff <= i_pin;
			sync_ff <= meta_ff;
			prev_ff <= sync_ff;
		end
	end

	assign o_level = sync_ff;
	assign o_rise = sync_ff && !prev_ff;
	assign o_fall = !sync_ff && prev_ff;

endmodule // edge_sync

`default_nettype wire

// >>> codec_audio_control_regs.sv
`timescale 1ns/100ps
`default_nettype none
`include "codec_regs_cfg.svh"

module codec_audio_control_regs
	import codec_regs_pkg::*;
(
	input wire logic i_clock,
	input wire logic i_rst_n,
	// serial control port pins
	input wire logic i_port_clock,
	input wire logic i_port_select_n,
	input wire logic i_port_data_in,
	output logic o_port_data_out,
	output logic o_port_data_out_en,
	// override controls held in the mode register outside this block
	input wire logic i_receive_override,
	input wire logic i_transmit_override,
	// frame strobe and byte from the receive serial input
	input wire logic i_frame_strobe,
	input wire logic [7:0] i_receive_serial_byte,
	input wire logic [7:0] i_encoder_byte,
	// per-frame data toward decoder and transmit serial output
	output logic [7:0] o_decoder_byte,
	output logic [7:0] o_transmit_serial_byte,
	// audio path controls
	output tx_input_type o_tx_input,
	output logic o_sidetone_enable,
	output rx_output_type o_rx_output,
	output logic o_ring_tone_route_enable,
	output logic o_highpass_bypass,
	output logic o_receive_signal_enable,
	output logic [3:0] o_tx_gain,
	output logic [3:0] o_sidetone_gain,
	output logic [3:0] o_earpiece_atten,
	output logic [3:0] o_external_amplifier_atten,
	output logic [3:0] o_tone_atten,
	output logic o_tone_source_one_select,
	output logic o_tone_source_two_select,
	output logic o_tone_square_wave,
	output logic o_tone_to_transmit,
	output logic [7:0] o_tone_freq_one,
	output logic [7:0] o_tone_freq_two
);

	// ------------------------------------------------------------------
	// pin synchronisers
	// ------------------------------------------------------------------
	logic sclk_rise;
	logic sclk_fall;
	logic sel_level;
	logic sel_fall;
	logic din_level;

	edge_sync u_sync_clk (
		.i_clock(i_clock),
		.i_rst_n(i_rst_n),
		.i_pin(i_port_clock),
		.o_level(),
		.o_rise(sclk_rise),
		.o_fall(sclk_fall)
	);

	edge_sync u_sync_sel (
		.i_clock(i_clock),
		.i_rst_n(i_rst_n),
		.i_pin(!i_port_select_n), // inverted: reset level is the idle level
		.o_level(sel_level),
		.o_rise(sel_fall),
		.o_fall()
	);

	edge_sync u_sync_din (
		.i_clock(i_clock),
		.i_rst_n(i_rst_n),
		.i_pin(i_port_data_in),
		.o_level(din_level),
		.o_rise(),
		.o_fall()
	);

	// ------------------------------------------------------------------
	// shifter and port sequencer
	// ------------------------------------------------------------------
	port_state_type state_ff;
	port_state_type nxt_state;
	logic [7:0] cmd_ff;
	logic [7:0] rd_byte;
	logic [7:0] sh_byte;
	logic sh_bit;
	logic sh_full;
	logic active;
	logic load_read;
	logic write_strobe;

	assign active = sel_level;

	serial_byte_shifter u_shifter (
		.i_clock(i_clock),
		.i_rst_n(i_rst_n),
		.i_load(load_read || sel_fall),
		.i_load_byte(load_read ? rd_byte : 8'h00),
		.i_shift(active && sclk_rise),
		.i_bit(din_level),
		.o_bit(sh_bit),
		.o_byte(sh_byte),
		.o_full(sh_full)
	);

	// address byte selects whether a data byte follows
	always_comb begin
		nxt_state = state_ff;
		case (state_ff)
			PORT_ADDR: begin
				if (sh_full) begin
					nxt_state = sh_byte[`CMD_SECOND_BYTE_BIT] ?
						PORT_DATA : PORT_DONE;
				end
			end
			PORT_DATA: begin
				if (sh_full) begin
					nxt_state = PORT_DONE;
				end
			end
			PORT_DONE: nxt_state = PORT_DONE;
			default: nxt_state = PORT_ADDR;
		endcase
		if (sel_fall || !sel_level) begin
			nxt_state = PORT_ADDR;
		end
	end

	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			state_ff <= PORT_ADDR;
		end else begin
			state_ff <= nxt_state;
		end
	end

	// keep the address byte for the data phase
	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			cmd_ff <= 8'h00;
		end else if (state_ff == PORT_ADDR && sh_full) begin
			cmd_ff <= sh_byte;
		end
	end

	logic [3:0] addr;
	logic is_read;
	assign addr = cmd_ff[`CMD_ADDR_MSB:`CMD_ADDR_LSB];
	assign is_read = cmd_ff[`CMD_READ_BIT];
	// read data reloads the shifter right after the address byte
	assign load_read = (state_ff == PORT_ADDR) && sh_full &&
		sh_byte[`CMD_READ_BIT] && sh_byte[`CMD_SECOND_BYTE_BIT];
	assign write_strobe = (state_ff == PORT_DATA) && sh_full && !is_read;

	// ------------------------------------------------------------------
	// registers
	// ------------------------------------------------------------------
	logic [7:0] rx_path_data_byte_ff;
	logic [7:0] tx_forced_data_byte_ff;
	logic [7:0] audio_path_control_ff;
	logic [7:0] tx_and_sidetone_gain_ff;
	logic [7:0] output_attenuation_ff;
	logic [7:0] tone_control_ff;
	logic [7:0] tone_freq_one_ff;
	logic [7:0] tone_freq_two_ff;

	// host write and per-frame capture share the receive byte; the
	// host write wins so an override byte is never overwritten
	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			rx_path_data_byte_ff <= `RST_BYTE;
		end else if (write_strobe && addr == `ADDR_RX_PATH_DATA_BYTE) begin
			rx_path_data_byte_ff <= sh_byte;
		end else if (i_frame_strobe && !i_receive_override) begin
			rx_path_data_byte_ff <= i_receive_serial_byte;
		end
	end

	// write-only forced transmit byte
	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			tx_forced_data_byte_ff <= `RST_BYTE;
		end else if (write_strobe && addr == `ADDR_TX_FORCED_DATA_BYTE) begin
			tx_forced_data_byte_ff <= sh_byte;
		end
	end

	// forbidden output code keeps the previous selection
	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			audio_path_control_ff <= `RST_BYTE;
		end else if (write_strobe && addr == `ADDR_AUDIO_PATH_CONTROL) begin
			audio_path_control_ff <= sh_byte;
			if (sh_byte[`PATH_OUTPUT_MSB:`PATH_OUTPUT_LSB] ==
				`OUTPUT_SEL_FORBIDDEN) begin
				audio_path_control_ff[`PATH_OUTPUT_MSB:`PATH_OUTPUT_LSB] <=
					audio_path_control_ff[`PATH_OUTPUT_MSB:`PATH_OUTPUT_LSB];
			end
		end
	end

	// gain and attenuation nibbles
	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			tx_and_sidetone_gain_ff <= `RST_BYTE;
			output_attenuation_ff <= `RST_BYTE;
		end else if (write_strobe) begin
			if (addr == `ADDR_TX_AND_SIDETONE_GAIN) begin
				tx_and_sidetone_gain_ff <= sh_byte;
			end
			if (addr == `ADDR_OUTPUT_ATTENUATION) begin
				output_attenuation_ff <= sh_byte;
			end
		end
	end

	// attenuation codes past the last step are clamped to -27 dB
	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			tone_control_ff <= `RST_BYTE;
		end else if (write_strobe && addr == `ADDR_TONE_CONTROL) begin
			tone_control_ff <= sh_byte;
			if (sh_byte[`TONE_ATTEN_MSB:`TONE_ATTEN_LSB] > `TONE_ATTEN_MAX) begin
				tone_control_ff[`TONE_ATTEN_MSB:`TONE_ATTEN_LSB] <=
					`TONE_ATTEN_MAX;
			end
		end
	end

	// tone frequency numbers
	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			tone_freq_one_ff <= `RST_BYTE;
			tone_freq_two_ff <= `RST_BYTE;
		end else if (write_strobe) begin
			if (addr == `ADDR_TONE_FREQ_ONE) begin
				tone_freq_one_ff <= sh_byte;
			end
			if (addr == `ADDR_TONE_FREQ_TWO) begin
				tone_freq_two_ff <= sh_byte;
			end
		end
	end

	// ------------------------------------------------------------------
	// read-back; forced transmit byte is write only and reads zero
	// ------------------------------------------------------------------
	always_comb begin
		case (sh_byte[`CMD_ADDR_MSB:`CMD_ADDR_LSB])
			`ADDR_RX_PATH_DATA_BYTE: rd_byte = rx_path_data_byte_ff;
			`ADDR_AUDIO_PATH_CONTROL: rd_byte = audio_path_control_ff;
			`ADDR_TX_AND_SIDETONE_GAIN: rd_byte = tx_and_sidetone_gain_ff;
			`ADDR_OUTPUT_ATTENUATION: rd_byte = output_attenuation_ff;
			`ADDR_TONE_CONTROL: rd_byte = tone_control_ff;
			`ADDR_TONE_FREQ_ONE: rd_byte = tone_freq_one_ff;
			`ADDR_TONE_FREQ_TWO: rd_byte = tone_freq_two_ff;
			default: rd_byte = 8'h00;
		endcase
	end

	// data out changes on the falling port clock, so the host samples a
	// settled bit on the next rise
	logic dout_ff;
	logic dout_en_ff;
	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			dout_ff <= 1'b0;
			dout_en_ff <= 1'b0;
		end else begin
			dout_en_ff <= active && (state_ff == PORT_DATA) && is_read;
			if (load_read) begin
				dout_ff <= rd_byte[7];
			end else if (sclk_fall) begin
				dout_ff <= sh_bit;
			end
		end
	end

	assign o_port_data_out = dout_ff;
	assign o_port_data_out_en = dout_en_ff;

	// ------------------------------------------------------------------
	// per-frame data and control outputs
	// ------------------------------------------------------------------
	logic [7:0] tx_byte_ff;
	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			tx_byte_ff <= `RST_BYTE;
		end else if (i_frame_strobe) begin
			tx_byte_ff <= i_transmit_override ?
				tx_forced_data_byte_ff : i_encoder_byte;
		end
	end

	// override feeds the stored byte, else the frame byte straight through
	assign o_decoder_byte = i_receive_override ?
		rx_path_data_byte_ff : i_receive_serial_byte;
	assign o_transmit_serial_byte = tx_byte_ff;

	assign o_tx_input = tx_input_type'(
		audio_path_control_ff[`PATH_INPUT_MSB:`PATH_INPUT_LSB]);
	assign o_sidetone_enable = audio_path_control_ff[`PATH_SIDETONE_BIT];
	assign o_rx_output = rx_output_type'(
		audio_path_control_ff[`PATH_OUTPUT_MSB:`PATH_OUTPUT_LSB]);
	assign o_ring_tone_route_enable =
		audio_path_control_ff[`PATH_RING_TONE_BIT];
	assign o_highpass_bypass =
		audio_path_control_ff[`PATH_HIGHPASS_BYPASS_BIT];
	assign o_receive_signal_enable =
		audio_path_control_ff[`PATH_RX_SIGNAL_BIT];
	assign o_tx_gain = tx_and_sidetone_gain_ff[7:4];
	assign o_sidetone_gain = tx_and_sidetone_gain_ff[3:0];
	assign o_earpiece_atten = output_attenuation_ff[7:4];
	assign o_external_amplifier_atten = output_attenuation_ff[3:0];
	assign o_tone_atten =
		tone_control_ff[`TONE_ATTEN_MSB:`TONE_ATTEN_LSB];
	assign o_tone_source_one_select = tone_control_ff[`TONE_SRC_MSB];
	assign o_tone_source_two_select = tone_control_ff[`TONE_SRC_LSB];
	assign o_tone_square_wave = tone_control_ff[`TONE_WAVE_BIT];
	assign o_tone_to_transmit = tone_control_ff[`TONE_TO_TX_BIT];
	assign o_tone_freq_one = tone_freq_one_ff;
	assign o_tone_freq_two = tone_freq_two_ff;

endmodule // codec_audio_control_regs

`default_nettype wire

// >>> codec_audio_control_regs_properties.sv
`timescale 1ns/100ps
`default_nettype none

module codec_audio_control_regs_properties
	import codec_regs_pkg::*;
(
	input wire logic i_clock,
	input wire logic i_rst_n,
	input wire logic i_port_select_n,
	input wire logic o_port_data_out_en,
	input wire logic i_receive_override,
	input wire logic i_transmit_override,
	input wire logic i_frame_strobe,
	input wire logic [7:0] i_receive_serial_byte,
	input wire logic [7:0] i_encoder_byte,
	input wire logic [7:0] o_decoder_byte,
	input wire logic [7:0] o_transmit_serial_byte,
	input wire tx_input_type o_tx_input,
	input wire logic o_sidetone_enable,
	input wire rx_output_type o_rx_output,
	input wire logic o_ring_tone_route_enable,
	input wire logic o_highpass_bypass,
	input wire logic o_receive_signal_enable,
	input wire logic [3:0] o_tone_atten
);
	default clocking cb @(posedge i_clock);
	endclocking
	default disable iff (!i_rst_n);

	// ------------------------------------------------------------------
	// frame path
	// ------------------------------------------------------------------
	a_decoder_passthru: assert property (
		!i_receive_override |-> o_decoder_byte == i_receive_serial_byte)
		else $error("decoder byte does not follow receive input");
	// stored byte must survive strobes while the override is held
	a_decoder_override_hold: assert property (
		(i_port_select_n [*8]) ##0
		(i_receive_override && $past(i_receive_override))
		|-> $stable(o_decoder_byte))
		else $error("stored receive byte changed under override");
	a_tx_encoder_byte: assert property (
		i_frame_strobe && !i_transmit_override
		|=> o_transmit_serial_byte == $past(i_encoder_byte))
		else $error("transmit byte is not the encoder byte");
	a_tx_byte_hold: assert property (
		!i_frame_strobe |=> $stable(o_transmit_serial_byte))
		else $error("transmit byte moved without a strobe");

	// ------------------------------------------------------------------
	// register fields and port
	// ------------------------------------------------------------------
	a_output_code_legal: assert property (
		o_rx_output != RX_OUT_FORBIDDEN)
		else $error("receive output shows the forbidden code");
	a_tone_atten_clamp: assert property (
		o_tone_atten <= 4'h9)
		else $error("tone attenuation above the last step");
	a_drive_only_selected: assert property (
		(i_port_select_n [*6]) |-> !o_port_data_out_en)
		else $error("read data driven while port deselected");
	// no traffic on the port means no change of the path settings
	a_path_idle_stable: assert property (
		(i_port_select_n [*8]) |=> $stable({o_tx_input, o_sidetone_enable,
		o_rx_output, o_ring_tone_route_enable, o_highpass_bypass,
		o_receive_signal_enable}))
		else $error("path control changed without port traffic");
endmodule // codec_audio_control_regs_properties

bind codec_audio_control_regs codec_audio_control_regs_properties chk (
	.i_clock(i_clock),
	.i_rst_n(i_rst_n),
	.i_port_select_n(i_port_select_n),
	.o_port_data_out_en(o_port_data_out_en),
	.i_receive_override(i_receive_override),
	.i_transmit_override(i_transmit_override),
	.i_frame_strobe(i_frame_strobe),
	.i_receive_serial_byte(i_receive_serial_byte),
	.i_encoder_byte(i_encoder_byte),
	.o_decoder_byte(o_decoder_byte),
	.o_transmit_serial_byte(o_transmit_serial_byte),
	.o_tx_input(o_tx_input),
	.o_sidetone_enable(o_sidetone_enable),
	.o_rx_output(o_rx_output),
	.o_ring_tone_route_enable(o_ring_tone_route_enable),
	.o_highpass_bypass(o_highpass_bypass),
	.o_receive_signal_enable(o_receive_signal_enable),
	.o_tone_atten(o_tone_atten)
);

`default_nettype wire

// >>> codec_port_host.sv
`timescale 1ns/100ps
`default_nettype none

// ------------------------------------------------------------------
// host side of the serial control port
// ------------------------------------------------------------------
module codec_port_host (
	input wire logic i_clock,
	input wire logic i_data_out,
	input wire logic i_data_out_en,
	output logic o_port_clock,
	output logic o_select_n,
	output logic o_data_in
);
	// long half period leaves slack for the device synchronisers
	localparam int HALF = 8;
	logic last_bit = 1'b0;
	wire line;

	// a released read line shows the inverse of its last value
	assign line = i_data_out_en ? i_data_out : ~last_bit;
	always @(posedge i_clock) begin
		if (i_data_out_en) begin
			last_bit <= i_data_out;
		end
	end

	initial begin
		o_port_clock = 1'b0;
		o_select_n = 1'b1;
		o_data_in = 1'b0;
	end

	task automatic wait_cycles(input int n);
		repeat (n) @(posedge i_clock);
		#1;
	endtask

	// one instruction: address byte then data byte, clock idles low
	task automatic xfer(input logic [7:0] addr, input logic [7:0] data,
		output logic [7:0] rdata);
		logic [15:0] word;
		word = {addr, data};
		rdata = 8'h00;
		wait_cycles(1);
		o_select_n = 1'b0;
		for (int i = 15; i >= 0; i--) begin
			o_data_in = word[i];
			wait_cycles(HALF);
			o_port_clock = 1'b1;
			if (i < 8) begin
				rdata[i] = line;
			end
			wait_cycles(HALF);
			o_port_clock = 1'b0;
		end
		wait_cycles(HALF);
		o_select_n = 1'b1;
		wait_cycles(HALF);
	endtask
endmodule // codec_port_host

`default_nettype wire

// >>> codec_audio_control_regs_test.sv
`timescale 1ns/100ps
`default_nettype none

module codec_audio_control_regs_test;
	import codec_regs_pkg::*;
	logic clock = 1'b0;
	logic rst_n = 1'b0;
	logic pclk, psel_n, pdin, pdout, pdout_en;
	logic rx_ov = 1'b0, tx_ov = 1'b0, strobe = 1'b0;
	logic [7:0] rx_byte = 8'h00, enc_byte = 8'h00, dec_byte, tx_byte;
	tx_input_type tx_input;
	rx_output_type rx_output;
	logic sidetone, ring, highpass_bypass, rse, src_one, src_two, square, tone_tx;
	logic [3:0] tx_gain, st_gain, ear_att, ext_att, tone_att;
	logic [7:0] freq_one, freq_two, q;
	logic [7:0] exp_reg [0:15];
	logic [11:0] corner [0:5] = '{12'h4FF, 12'h418, 12'h7F0, 12'h7A5,
		12'hA5A, 12'h1C3};
	logic [31:0] r;
	logic [3:0] a;
	int fails = 0, tests_run = 0, n;
	integer seed;

	always #2 clock = ~clock;

	codec_port_host host (.i_clock(clock), .i_data_out(pdout),
		.i_data_out_en(pdout_en), .o_port_clock(pclk),
		.o_select_n(psel_n), .o_data_in(pdin));

	codec_audio_control_regs dut (.i_clock(clock), .i_rst_n(rst_n),
		.i_port_clock(pclk), .i_port_select_n(psel_n),
		.i_port_data_in(pdin), .o_port_data_out(pdout),
		.o_port_data_out_en(pdout_en), .i_receive_override(rx_ov),
		.i_transmit_override(tx_ov), .i_frame_strobe(strobe),
		.i_receive_serial_byte(rx_byte), .i_encoder_byte(enc_byte),
		.o_decoder_byte(dec_byte), .o_transmit_serial_byte(tx_byte),
		.o_tx_input(tx_input), .o_sidetone_enable(sidetone),
		.o_rx_output(rx_output), .o_ring_tone_route_enable(ring),
		.o_highpass_bypass(highpass_bypass), .o_receive_signal_enable(rse),
		.o_tx_gain(tx_gain), .o_sidetone_gain(st_gain),
		.o_earpiece_atten(ear_att), .o_external_amplifier_atten(ext_att),
		.o_tone_atten(tone_att), .o_tone_source_one_select(src_one),
		.o_tone_source_two_select(src_two), .o_tone_square_wave(square),
		.o_tone_to_transmit(tone_tx), .o_tone_freq_one(freq_one),
		.o_tone_freq_two(freq_two));

	// ------------------------------------------------------------------
	// expectation helpers
	// ------------------------------------------------------------------
	function automatic logic [7:0] stored(input logic [3:0] ad,
		input logic [7:0] d, input logic [7:0] old);
		if (ad == 4'h4 && d[4:3] == 2'h3) begin
			return {d[7:5], old[4:3], d[2:0]};
		end
		if (ad == 4'h7 && d[7:4] > 4'h9) begin
			return {4'h9, d[3:0]};
		end
		return d;
	endfunction

	// forced transmit byte is write only, so it reads as zero
	function automatic logic [7:0] readback(input logic [3:0] ad);
		return (ad == 4'h2 || (ad >= 4'h4 && ad <= 4'h9)) ?
			exp_reg[ad] : 8'h00;
	endfunction

	task automatic check(input logic [7:0] seen, input logic [7:0] want);
		tests_run++;
		if (seen !== want) begin
			fails++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, want);
		end
	endtask

	task automatic wr(input logic [3:0] ad, input logic [7:0] d);
		logic [7:0] rq;
		host.xfer({1'b0, ad, 2'b01, 1'b0}, d, rq);
		if (ad >= 4'h2 && ad <= 4'h9) begin
			exp_reg[ad] = stored(ad, d, exp_reg[ad]);
		end
	endtask

	task automatic rd_chk(input logic [3:0] ad);
		logic [7:0] rq;
		host.xfer({1'b0, ad, 2'b11, 1'b0}, 8'h00, rq);
		check(rq, readback(ad));
	endtask

	task automatic outs_chk;
		check({tx_input, sidetone, rx_output, ring, highpass_bypass, rse},
			exp_reg[4]);
		check({tx_gain, st_gain}, exp_reg[5]);
		check({ear_att, ext_att}, exp_reg[6]);
		check({tone_att, src_one, src_two, square, tone_tx},
			exp_reg[7]);
		check(freq_one, exp_reg[8]);
		check(freq_two, exp_reg[9]);
	endtask

	task automatic frame(input logic orx, input logic otx,
		input logic [7:0] rb, input logic [7:0] eb);
		@(posedge clock);
		#1;
		rx_ov = orx;
		tx_ov = otx;
		rx_byte = rb;
		enc_byte = eb;
		strobe = 1'b1;
		@(posedge clock);
		#1;
		strobe = 1'b0;
		check(tx_byte, otx ? exp_reg[3] : eb);
		if (!orx) begin
			exp_reg[2] = rb;
		end
		check(dec_byte, orx ? exp_reg[2] : rb);
	endtask

	task give_verdict;
		if (fails == 0 && tests_run > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	// ------------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------------
	initial begin
		seed = 32'hA2414387;
		for (n = 0; n < 16; n++) exp_reg[n] = 8'h00;
		repeat (4) @(posedge clock);
		#1;
		rst_n = 1'b1;
		repeat (8) @(posedge clock);
		for (n = 0; n < 16; n++) rd_chk(4'(n));
		outs_chk;
		// every input, output and tone source code, forbidden one included
		for (n = 0; n < 4; n++) begin
			wr(4'h4, {2'(n), 1'b0, 2'(n), 3'h5});
			wr(4'h7, {4'(n), 2'(n), 2'h1});
			outs_chk;
		end
		// refused codes, clamp and writes outside the block
		for (n = 0; n < 6; n++) begin
			wr(corner[n][11:8], corner[n][7:0]);
			rd_chk(corner[n][11:8]);
			outs_chk;
		end
		// address byte without a second byte ends the instruction
		host.xfer(8'h28, 8'hFF, q);
		outs_chk;
		for (n = 0; n < 24; n++) begin
			r = $random(seed);
			a = 4'h2 + {1'b0, r[2:0]};
			wr(a, r[15:8]);
			rd_chk(a);
			outs_chk;
		end
		for (n = 0; n < 8; n++) begin
			r = $random(seed);
			wr(4'h3, r[7:0]);
			frame(r[8], r[9], r[23:16], r[31:24]);
			frame(r[10], r[9], r[31:24], r[23:16]);
			rd_chk(4'h2);
		end
		give_verdict;
	end

	// about 28k cycles of port traffic expected; give up at 50k cycles
	initial begin
		#200000;
		fails++;
		give_verdict;
	end
endmodule // codec_audio_control_regs_test

`default_nettype wire
